// >>> include/aps_pkg.sv
package aps_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned OC_PERSIST_NS = 630000;
  localparam int unsigned OC_PERSIST_CYC_DEF = OC_PERSIST_NS / CLK_PERIOD_NS;
  localparam int unsigned OC_CNT_W = 16;

  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;

  localparam int unsigned CTRL_MUTE_BIT = 0;
  localparam logic [31:0] CTRL_RST_VAL = 32'h0000_0000;

  localparam int unsigned STAT_UV_BIT = 0;
  localparam int unsigned STAT_OC_BIT = 1;
  localparam int unsigned STAT_OTE_BIT = 2;
  localparam int unsigned STAT_WARN_BIT = 3;
  localparam int unsigned STAT_LIMIT_BIT = 4;
  localparam int unsigned STAT_HIZ_BIT = 5;
  localparam int unsigned STAT_PD_BIT = 6;
  localparam int unsigned STAT_PIN_BIT = 7;
  localparam int unsigned STAT_MODE_LSB = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    APS_SEL_NONE = 3'h1,
    APS_SEL_CTRL = 3'h2,
    APS_SEL_STAT = 3'h4
  } aps_sel_e;

  typedef enum logic [1:0] {
    APS_MODE_BTL2 = 2'h0,
    APS_MODE_BTL1 = 2'h1,
    APS_MODE_SE   = 2'h2,
    APS_MODE_RSVD = 2'h3
  } aps_mode_e;

  typedef struct packed {
    logic       reset_pin_n;
    logic       mode_select_high;
    logic       mode_select_low;
    logic       gate_drive_supply_ab_ok;
    logic       gate_drive_supply_cd_ok;
    logic       logic_supply_rail_ok;
    logic [1:0] oc_det;
    logic       temp_warn_cmp;
    logic       temp_release_cmp;
    logic       temp_shut_cmp;
  } aps_sense_s;

endpackage

// >>> logic/aps_sync.sv
`timescale 1ns/1ps
`default_nettype none
module aps_sync
  import aps_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire aps_sense_s d,
  output var  aps_sense_s q
);

  localparam int unsigned W = $bits(aps_sense_s);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // Reset value of zero reads as reset pin low and supplies failed, the safe side.
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= d[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign q = aps_sense_s'(sync_q);

endmodule // aps_sync
`default_nettype wire

// >>> logic/aps_supervisor.sv
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// (R1) Half-bridges Hi-Z until all supplies good.
// (R2) Pulldowns in reset, bridged modes only.
// (R3) Controller holds reset low 200 us; aps_ctrl_model holds it LOW_CYC cycles, 240 ns.
// (R4) Alarm open-drain low; warning push-pull high.
// (R5) Any fault: Hi-Z and alarm low.
// (R6) Warning above 125 C, no shutdown.
// (R7) Alarm and warning encode fault class.
// (R8) Reset low forces alarm inactive high.
// (R9) Non-latched faults recover automatically.
// (R10) Controller resets 300 ms after overcurrent; aps_ctrl_model waits WAIT_CYC cycles, 400 ns, if the alarm is low at a request.
// (R11) Each PWM input low 50 ns/frame.
// (R12) Modulation index capped at 96.1 percent.
// (R13) Overcurrent first limits current cycle-by-cycle.
// (R14) Persistent overcurrent latches Hi-Z shutdown.
// (R15) Overcurrent in either pair stops all.
// (R16) Above 150 C latch thermal shutdown.
// (R17) Thermal latch clears only under reset.
// (R18) Supply low: Hi-Z, alarm, auto resume.
// (R19) Power-on clear resets overload state.
// (R20) Reset low mutes all half-bridges.
// (R21) Reset rising edge releases overcurrent latch.
// (R22) SE mode: controller pulses PWM low.
// (R23) Warning clears after 25 degree drop.
// (R24) Reserved mode keeps outputs Hi-Z.
// (R25) Synchronise comparator and reset inputs.
module aps_supervisor
  import aps_pkg::*;
#(
  parameter int unsigned OC_PERSIST_CYC = OC_PERSIST_CYC_DEF
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire aps_sense_s        sense,
  output var  logic              bridge_hiz,
  output var  logic              bootstrap_pulldown_en,
  output var  logic              current_limit,
  output var  logic              thermal_warning,
  input  wire logic              fault_n_i,
  output var  logic              fault_n_o,
  output var  logic              fault_n_oe_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  function automatic aps_sel_e reg_sel(input logic [ADDR_W-1:0] a);
    if (a == CTRL_OFS) begin
      return APS_SEL_CTRL;
    end else if (a == STAT_OFS) begin
      return APS_SEL_STAT;
    end else begin
      return APS_SEL_NONE;
    end
  endfunction

  aps_sense_s s;
  aps_sync u_sync ( // see (R25)
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (sense),
    .q       (s)
  );

  logic [31:0]         ctrl_q;
  logic                rst_prev_q;
  logic [OC_CNT_W-1:0] oc_cnt_q;
  logic                oc_trip_q;
  logic                ote_q;
  logic                warn_q;
  logic                hiz_q;
  logic                pd_q;
  logic                limit_q;
  logic                fault_drive_q;
  logic                warn_out_q;

  logic                aw_full_q;
  logic                w_full_q;
  logic [ADDR_W-1:0]   awaddr_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;

  aps_mode_e mode;
  logic      supply_ok;
  logic      oc_any;
  logic      rst_rise;
  logic      fault_any;

  assign mode      = aps_mode_e'({s.mode_select_high, s.mode_select_low});
  assign supply_ok = s.gate_drive_supply_ab_ok & s.gate_drive_supply_cd_ok & s.logic_supply_rail_ok;
  assign oc_any    = |s.oc_det; // see (R15)
  assign rst_rise  = s.reset_pin_n & ~rst_prev_q;
  // Undervoltage is not latched, so it drops out of this term once supplies recover.
  assign fault_any = ~supply_ok | oc_trip_q | ote_q; // see (R9)

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_prev_q <= 1'b0;
    end else begin
      rst_prev_q <= s.reset_pin_n;
    end
  end

  // Counting only consecutive cycles lets short music transients ride on the limiter.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin // see (R19)
      oc_cnt_q  <= '0;
      oc_trip_q <= 1'b0;
    end else begin
      if (!oc_any || oc_trip_q) begin
        oc_cnt_q <= '0;
      end else begin
        oc_cnt_q <= oc_cnt_q + 1'b1;
      end
      if (oc_any && (oc_cnt_q >= OC_CNT_W'(OC_PERSIST_CYC - 1))) begin
        oc_trip_q <= 1'b1; // see (R14)
      end else if (rst_rise) begin
        oc_trip_q <= 1'b0; // see (R21)
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ote_q <= 1'b0;
    end else if (s.temp_shut_cmp) begin
      ote_q <= 1'b1; // see (R16)
    end else if (!s.reset_pin_n) begin
      ote_q <= 1'b0; // see (R17)
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      warn_q <= 1'b0;
    end else if (s.temp_warn_cmp) begin
      warn_q <= 1'b1; // see (R6)
    end else if (s.temp_release_cmp) begin
      warn_q <= 1'b0; // see (R23)
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST_VAL;
    end else if (s_axi_bvalid == 1'b0 && aw_full_q && w_full_q && reg_sel(awaddr_q) == APS_SEL_CTRL
                 && wstrb_q[0]) begin
      ctrl_q <= {24'h00_0000, wdata_q[7:0]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hiz_q         <= 1'b1;
      pd_q          <= 1'b0;
      limit_q       <= 1'b0;
      fault_drive_q <= 1'b0;
      warn_out_q    <= 1'b0;
    end else begin
      // see (R1) (R5) (R18) (R20) (R24)
      hiz_q         <= fault_any | ~s.reset_pin_n | (mode == APS_MODE_RSVD) | ctrl_q[CTRL_MUTE_BIT];
      pd_q          <= ~s.reset_pin_n & (mode == APS_MODE_BTL2 || mode == APS_MODE_BTL1); // see (R2)
      limit_q       <= oc_any; // see (R13)
      fault_drive_q <= fault_any & s.reset_pin_n; // see (R5) (R8)
      warn_out_q    <= warn_q & ~ote_q; // see (R7)
    end
  end

  assign bridge_hiz            = hiz_q;
  assign bootstrap_pulldown_en = pd_q;
  assign current_limit         = limit_q;
  assign thermal_warning       = warn_out_q; // see (R4)
  assign fault_n_o             = 1'b0; // see (R4)
  assign fault_n_oe_n          = ~fault_drive_q;

  assign s_axi_awready = ~aw_full_q & ~bvalid_q;
  assign s_axi_wready  = ~w_full_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (aw_full_q && w_full_q && !bvalid_q) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (reg_sel(awaddr_q) == APS_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q  <= RESP_OKAY;
      if (reg_sel(s_axi_araddr) == APS_SEL_CTRL) begin
        rdata_q <= ctrl_q;
      end else if (reg_sel(s_axi_araddr) == APS_SEL_STAT) begin
        rdata_q <= '0;
        rdata_q[STAT_UV_BIT]    <= ~supply_ok;
        rdata_q[STAT_OC_BIT]    <= oc_trip_q;
        rdata_q[STAT_OTE_BIT]   <= ote_q;
        rdata_q[STAT_WARN_BIT]  <= warn_q;
        rdata_q[STAT_LIMIT_BIT] <= limit_q;
        rdata_q[STAT_HIZ_BIT]   <= hiz_q;
        rdata_q[STAT_PD_BIT]    <= pd_q;
        rdata_q[STAT_PIN_BIT]   <= fault_n_i;
        rdata_q[STAT_MODE_LSB+:2] <= mode;
      end else begin
        rdata_q <= '0;
        rresp_q <= RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_reset_mute;
    !s.reset_pin_n |=> bridge_hiz && !fault_drive_q;
  endproperty
  a_reset_mute: assert property (p_reset_mute) else $error("Reset low did not mute or clear alarm."); // see (R20)

  property p_se_no_pd;
    mode == APS_MODE_SE |=> !bootstrap_pulldown_en;
  endproperty
  a_se_no_pd: assert property (p_se_no_pd) else $error("Pulldown enabled in single-ended mode."); // see (R2)

  property p_btl_pd;
    (!s.reset_pin_n && mode == APS_MODE_BTL1) |=> bootstrap_pulldown_en;
  endproperty
  a_btl_pd: assert property (p_btl_pd) else $error("Pulldown missing in bridged reset."); // see (R2)

  property p_uv_fault;
    (!supply_ok && s.reset_pin_n) |=> bridge_hiz && !fault_n_oe_n;
  endproperty
  a_uv_fault: assert property (p_uv_fault) else $error("Undervoltage did not shut down."); // see (R18)

  property p_ote_hold;
    ote_q && s.reset_pin_n |=> ote_q;
  endproperty
  a_ote_hold: assert property (p_ote_hold) else $error("Thermal latch dropped without reset."); // see (R17)

  property p_oc_limit;
    oc_any |=> current_limit;
  endproperty
  a_oc_limit: assert property (p_oc_limit) else $error("Current limit not applied."); // see (R13)

  property p_oc_release;
    rst_rise && !oc_any |=> !oc_trip_q;
  endproperty
  a_oc_release: assert property (p_oc_release) else $error("Overcurrent latch not released."); // see (R21)

  property p_oc_hold;
    oc_trip_q && !rst_rise |=> oc_trip_q ##1 bridge_hiz;
  endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("Overcurrent latch not held."); // see (R14)

  property p_warn_code;
    ote_q |=> !thermal_warning;
  endproperty
  a_warn_code: assert property (p_warn_code) else $error("Warning shown during thermal shutdown."); // see (R7)

  property p_warn_hyst;
    warn_q && !s.temp_release_cmp |=> warn_q;
  endproperty
  a_warn_hyst: assert property (p_warn_hyst) else $error("Warning cleared before release point."); // see (R23)

  property p_rsvd_hiz;
    mode == APS_MODE_RSVD |=> bridge_hiz;
  endproperty
  a_rsvd_hiz: assert property (p_rsvd_hiz) else $error("Reserved mode not held in Hi-Z."); // see (R24)

  c_oc_trip: cover property ($rose(oc_trip_q));
  c_ote: cover property ($rose(ote_q) ##[1:20] !ote_q);
  c_warn: cover property ($rose(thermal_warning) ##[1:50] $fell(thermal_warning));

endmodule // aps_supervisor
`default_nettype wire

// >>> sim/aps_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Controller side: drives the device reset pin and watches the alarm wire.
module aps_ctrl_model #(
  parameter int unsigned LOW_CYC     = 12,
  parameter int unsigned WAIT_CYC    = 20,
  parameter int unsigned FRAME_CYC   = 130,
  parameter int unsigned LOW_MIN_CYC = 6
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic req,
  input  wire logic alarm_n,
  output var  logic reset_pin_n,
  output var  logic busy,
  output var  logic pwm
);
  logic [7:0] cnt_q;
  logic [7:0] frm_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 8'(LOW_CYC);
    end else if (req && cnt_q == 8'h00) begin
      // A tripped stage is left alone for a while first; an early reset would re-stress it.
      cnt_q <= alarm_n ? 8'(LOW_CYC) : 8'(LOW_CYC + WAIT_CYC);
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  assign reset_pin_n = !(cnt_q != 8'h00 && cnt_q <= 8'(LOW_CYC));
  assign busy        = cnt_q != 8'h00;
  // One carrier period; the low slot meets both the 50 ns floor and the 96.1 percent cap.
  always_ff @(posedge aclk) begin
    if (!aresetn || frm_q == 8'(FRAME_CYC - 1)) begin
      frm_q <= 8'h00;
    end else begin
      frm_q <= frm_q + 8'h01;
    end
  end
  // Held low through reset; the frame counter runs on, so release can fall mid-frame, not at a low pulse.
  assign pwm = reset_pin_n && (frm_q >= 8'(LOW_MIN_CYC));
endmodule // aps_ctrl_model
`default_nettype wire

// >>> sim/amp_protection_supervisor_test.sv
`timescale 1ns/1ps
`default_nettype none
module amp_protection_supervisor_test;
  import aps_pkg::*;
  logic        aclk, aresetn, req, pin_n, busy, hiz, pd, lim, warn, f_o, f_oe_n, alarm;
  logic [1:0]  mode_q, oc_q, bresp, rresp;
  logic [2:0]  sup_q, tmp_q;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        pwm;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  aps_sense_s  sense;
  int          bad_count, comparisons;

  assign sense = {pin_n, mode_q, sup_q, oc_q, tmp_q};
  // The alarm wire has a pullup, so a released driver reads high.
  assign alarm = f_oe_n ? 1'h1 : f_o;

  aps_supervisor #(.OC_PERSIST_CYC(8)) aps_supervisor_i (
    .aclk(aclk), .aresetn(aresetn), .sense(sense), .bridge_hiz(hiz),
    .bootstrap_pulldown_en(pd), .current_limit(lim), .thermal_warning(warn),
    .fault_n_i(alarm), .fault_n_o(f_o), .fault_n_oe_n(f_oe_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  aps_ctrl_model aps_ctrl_model_i (
    .aclk(aclk), .aresetn(aresetn), .req(req), .alarm_n(alarm),
    .reset_pin_n(pin_n), .busy(busy), .pwm(pwm));

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Sense inputs take three edges to reach the outputs, four through the latches; six leaves margin.
  task settle;
    cyc(6);
    #1;
  endtask

  task outs(input logic h, input logic a, input logic w);
    chk("hiz", 32'(hiz), 32'(h));
    chk("alarm", 32'(alarm), 32'(a));
    chk("warn", 32'(warn), 32'(w));
  endtask

  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    // Each channel lets go on its own ready; only the watchdog bounds the wait for the answer.
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    chk("bresp", 32'(bresp), 32'(er));
  endtask

  task axr(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed, input logic [31:0] m);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    chk("rresp", 32'(rresp), 32'(er));
    chk("rdata", rdata & m, ed);
  endtask

  task rst_cycle(input logic [1:0] m);
    @(posedge aclk);
    mode_q <= m;
    req <= 1'h1;
    @(posedge aclk);
    req <= 1'h0;
    while (pin_n) @(posedge aclk);
    settle;
    chk("pd", 32'(pd), 32'(m < 2'h2));
    chk("hiz", 32'(hiz), 32'h1);
    chk("alarm", 32'(alarm), 32'h1);
    chk("pwm", 32'(pwm), 32'h0);
    while (busy) @(posedge aclk);
    settle;
  endtask

  task t_power;
    cyc(7);
    #1;
    chk("pd", 32'(pd), 32'h1);
    outs(1'h1, 1'h1, 1'h0);
    while (busy) @(posedge aclk);
    settle;
    outs(1'h1, 1'h0, 1'h0);
    for (int i = 0; i < 3; i++) begin
      @(posedge aclk);
      sup_q[i] <= 1'h1;
      settle;
      chk("hiz", 32'(hiz), 32'(i < 2));
    end
    outs(1'h0, 1'h1, 1'h0);
    $display("power-up test done");
  endtask

  task t_modes;
    for (int k = 1; k < 5; k++) begin
      rst_cycle(2'(k));
      chk("hiz", 32'(hiz), 32'(k == 3));
    end
    $display("mode test done");
  endtask

  task t_uv;
    for (int i = 0; i < 3; i++) begin
      @(posedge aclk);
      sup_q <= 3'h7 ^ (3'h1 << i);
      settle;
      outs(1'h1, 1'h0, 1'h0);
      @(posedge aclk);
      sup_q <= 3'h7;
      settle;
      outs(1'h0, 1'h1, 1'h0);
    end
    $display("undervoltage test done");
  endtask

  task t_warn;
    @(posedge aclk);
    tmp_q <= 3'h4;
    settle;
    outs(1'h0, 1'h1, 1'h1);
    @(posedge aclk);
    tmp_q <= 3'h0;
    settle;
    outs(1'h0, 1'h1, 1'h1);
    @(posedge aclk);
    sup_q <= 3'h6;
    settle;
    outs(1'h1, 1'h0, 1'h1);
    @(posedge aclk);
    sup_q <= 3'h7;
    tmp_q <= 3'h2;
    settle;
    outs(1'h0, 1'h1, 1'h0);
    $display("warning test done");
  endtask

  task t_oc;
    @(posedge aclk);
    oc_q <= 2'h1;
    cyc(5);
    #1;
    chk("lim", 32'(lim), 32'h1);
    chk("hiz", 32'(hiz), 32'h0);
    @(posedge aclk);
    oc_q <= 2'h0;
    settle;
    outs(1'h0, 1'h1, 1'h0);
    chk("lim", 32'(lim), 32'h0);
    @(posedge aclk);
    oc_q <= 2'h2;
    cyc(14);
    oc_q <= 2'h0;
    settle;
    outs(1'h1, 1'h0, 1'h0);
    axr(STAT_OFS, RESP_OKAY, 32'h2, 32'h2);
    rst_cycle(2'h0);
    outs(1'h0, 1'h1, 1'h0);
    $display("overcurrent test done");
  endtask

  task t_therm;
    @(posedge aclk);
    tmp_q <= 3'h5;
    settle;
    outs(1'h1, 1'h0, 1'h0);
    @(posedge aclk);
    tmp_q <= 3'h2;
    settle;
    outs(1'h1, 1'h0, 1'h0);
    rst_cycle(2'h0);
    outs(1'h0, 1'h1, 1'h0);
    $display("thermal test done");
  endtask

  task t_por;
    @(posedge aclk);
    oc_q <= 2'h3;
    cyc(14);
    oc_q <= 2'h0;
    settle;
    outs(1'h1, 1'h0, 1'h0);
    @(posedge aclk);
    aresetn <= 1'h0;
    cyc(5);
    aresetn <= 1'h1;
    // The pin is still held low here, so no pin edge can have released the latch.
    axr(STAT_OFS, RESP_OKAY, 32'h0, 32'h2);
    while (busy) @(posedge aclk);
    settle;
    outs(1'h0, 1'h1, 1'h0);
    $display("power-on clear test done");
  endtask

  task t_axi;
    axr(CTRL_OFS, RESP_OKAY, CTRL_RST_VAL, 32'hffff_ffff);
    axw(CTRL_OFS, 32'h1, RESP_OKAY);
    axr(STAT_OFS, RESP_OKAY, 32'h20, 32'h320);
    axw(STAT_OFS, 32'h0, RESP_OKAY);
    axw(CTRL_OFS, 32'h0, RESP_OKAY);
    @(posedge aclk);
    wstrb <= 4'h0;
    axw(CTRL_OFS, 32'h1, RESP_OKAY);
    @(posedge aclk);
    wstrb <= 4'hf;
    axr(CTRL_OFS, RESP_OKAY, 32'h0, 32'hffff_ffff);
    axw(8'h08, 32'h1, RESP_SLVERR);
    axr(8'h08, RESP_SLVERR, 32'h0, 32'hffff_ffff);
    settle;
    chk("hiz", 32'(hiz), 32'h0);
    $display("register test done");
  endtask

  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end

  initial begin
    cyc(6000);
    bad_count++;
    stop_test;
  end

  initial begin
    {aresetn, req, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {mode_q, oc_q, sup_q, awaddr, araddr, wdata} = 0;
    tmp_q = 3'h2;
    wstrb = 4'hf;
    cyc(5);
    aresetn <= 1'h1;
    t_power;
    t_modes;
    t_uv;
    t_warn;
    t_oc;
    t_therm;
    t_por;
    t_axi;
    stop_test;
  end
endmodule // amp_protection_supervisor_test
`default_nettype wire
